// >>> hdl/bfr_pkg.sv
// Constants of the drawing engine format register bank.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package bfr_pkg;

    // ==========================================================
    // Register indices and byte addresses (byte = 4 * index)
    // ==========================================================
    localparam logic [7:0] IDX_FG_COLOR   = 8'h14;
    localparam logic [7:0] IDX_STR_HEIGHT = 8'h1c;
    localparam logic [7:0] IDX_FMT_SELECT = 8'h1e;
    localparam logic [7:0] IDX_CMP_COLOR  = 8'h20;
    localparam int         ADDR_W         = 8;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int HEIGHT_W      = 12;
    localparam int FMT_LOC_LSB   = 0;
    localparam int FMT_PIX_LSB   = 4;
    localparam int FMT_COL_LSB   = 8;
    localparam int FMT_ROW_LSB   = 11;
    localparam int FMT_OVR_BIT   = 14;
    localparam int COLOR_W       = 24;

    // Writable bits of the format register
    localparam logic [15:0] FMT_WMASK = 16'h7f3f;

    // ==========================================================
    // Codes and reset values
    // ==========================================================
    localparam logic [3:0] LOC_LINEAR = 4'hf;
    localparam logic [1:0] PIX_8      = 2'h0;
    localparam logic [1:0] PIX_16     = 2'h1;
    localparam logic [1:0] PIX_32     = 2'h2;
    localparam logic [1:0] PIX_24     = 2'h3;
    localparam logic [31:0] RST_VALUE = 32'h0000_0000;

    typedef enum logic [1:0] {
        BFR_IDLE = 2'b01,
        BFR_ACK  = 2'b10
    } bfr_bus_e;

endpackage : bfr_pkg

// >>> hdl/bfr_regs.sv
// Format, stretch and color compare registers of the drawing engine.
// Assumes an Avalon-MM master on the engine clock; the datapath reads
// the decoded fields and supplies one pattern row for rotation.
//
// What this block does
// - Stretch height holds 12 bits, rest reserved
// - Overwrite clear: pattern address only when linear
// - Overwrite set: pattern address in every mode
// - Pattern row valid if overwrite or loc 11xx
// - Pattern column valid under same condition
// - Nonzero column rotates pattern row horizontally
// - Pixel format: 8, 16, 32, packed 24 bpp
// - Location all ones is linear, else X-Y
// - X-Y origin top-left; linear counts sequentially
// - Compare value follows selected pixel format
// - Compare layout per format, bits 31:24 reserved
// - Foreground color laid out like compare value
`timescale 1ns/1ps
`default_nettype none

module bfr_regs #(
    parameter int PIX_W = 8,
    parameter int PAT_N = 8
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    input  wire logic [bfr_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                      i_avs_read,
    input  wire logic                      i_avs_write,
    input  wire logic [31:0]               i_avs_writedata,
    input  wire logic [3:0]                i_avs_byteenable,
    output logic      [31:0]               o_avs_readdata,
    output logic                           o_avs_waitrequest,
    input  wire logic [PIX_W*PAT_N-1:0]    i_pat_row,
    output logic      [PIX_W*PAT_N-1:0]    o_pat_row_rot,
    output logic      [11:0]               o_stretch_height,
    output logic      [1:0]                o_pixel_format,
    output logic                           o_linear_mode,
    output logic                           o_xy_mode,
    output logic                           o_pat_addr_en,
    output logic                           o_pat_origin_valid,
    output logic      [2:0]                o_pat_origin_row,
    output logic      [2:0]                o_pat_origin_col,
    output logic      [23:0]               o_color_compare,
    output logic      [23:0]               o_foreground_color
);

    // ==========================================================
    // Bus handshake: one wait state per access
    // ==========================================================
    bfr_pkg::bfr_bus_e state_reg;
    bfr_pkg::bfr_bus_e state_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    wire logic         req;
    wire logic         done;
    wire logic [7:0]   idx;

    assign req  = i_avs_read | i_avs_write;
    assign done = req & (state_reg == bfr_pkg::BFR_ACK);
    assign idx  = {2'h0, i_avs_address[bfr_pkg::ADDR_W-1:2]};
    assign o_avs_waitrequest = req & ~done;
    assign o_avs_readdata    = rdata_reg;

    always_comb
    begin
        unique case (state_reg)
            bfr_pkg::BFR_IDLE: state_next = req ? bfr_pkg::BFR_ACK
                                                : bfr_pkg::BFR_IDLE;
            bfr_pkg::BFR_ACK:  state_next = bfr_pkg::BFR_IDLE;
            default:           state_next = bfr_pkg::BFR_IDLE;
        endcase
    end

    // ==========================================================
    // Storage; only defined bits are written, so reserved bits read zero
    // ==========================================================
    logic [11:0] height_reg;
    logic [15:0] fmt_reg;
    logic [23:0] cmp_reg;
    logic [23:0] fg_reg;
    wire logic   wr;
    wire logic [31:0] bmask;

    assign wr    = i_avs_write & done;
    assign bmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    wire logic [31:0] wmerge_h;
    wire logic [31:0] wmerge_f;
    wire logic [31:0] wmerge_c;
    wire logic [31:0] wmerge_g;
    assign wmerge_h = (i_avs_writedata & bmask) | ({20'h0, height_reg} & ~bmask);
    assign wmerge_f = (i_avs_writedata & bmask) | ({16'h0, fmt_reg} & ~bmask);
    assign wmerge_c = (i_avs_writedata & bmask) | ({8'h0, cmp_reg} & ~bmask);
    assign wmerge_g = (i_avs_writedata & bmask) | ({8'h0, fg_reg} & ~bmask);

    always_comb
    begin
        unique case (idx)
            bfr_pkg::IDX_STR_HEIGHT: rdata_next = {20'h0, height_reg};
            bfr_pkg::IDX_FMT_SELECT: rdata_next = {16'h0, fmt_reg};
            bfr_pkg::IDX_CMP_COLOR:  rdata_next = {8'h0, cmp_reg};
            bfr_pkg::IDX_FG_COLOR:   rdata_next = {8'h0, fg_reg};
            default:                 rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= bfr_pkg::BFR_IDLE;
            rdata_reg <= bfr_pkg::RST_VALUE;
        end
        else
        begin
            state_reg <= state_next;
            if (i_avs_read && !done)
                rdata_reg <= rdata_next;
        end
    end

    // Contents are meaningless until written; zero only for determinism
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            height_reg <= bfr_pkg::RST_VALUE[11:0];
            fmt_reg    <= bfr_pkg::RST_VALUE[15:0];
            cmp_reg    <= bfr_pkg::RST_VALUE[23:0];
            fg_reg     <= bfr_pkg::RST_VALUE[23:0];
        end
        else if (wr)
        begin
            if (idx == bfr_pkg::IDX_STR_HEIGHT)
                height_reg <= wmerge_h[11:0];
            if (idx == bfr_pkg::IDX_FMT_SELECT)
                fmt_reg <= wmerge_f[15:0] & bfr_pkg::FMT_WMASK;
            if (idx == bfr_pkg::IDX_CMP_COLOR)
                cmp_reg <= wmerge_c[23:0];
            if (idx == bfr_pkg::IDX_FG_COLOR)
                fg_reg <= wmerge_g[23:0];
        end
    end

    // ==========================================================
    // Field decode toward the drawing datapath
    // ==========================================================
    wire logic [3:0] loc;
    wire logic       ovr;
    wire logic [2:0] row_raw;
    wire logic [2:0] col_raw;
    wire logic [23:0] fmt_mask;

    assign loc     = fmt_reg[bfr_pkg::FMT_LOC_LSB +: 4];
    assign ovr     = fmt_reg[bfr_pkg::FMT_OVR_BIT];
    assign row_raw = fmt_reg[bfr_pkg::FMT_ROW_LSB +: 3];
    assign col_raw = fmt_reg[bfr_pkg::FMT_COL_LSB +: 3];

    assign o_stretch_height = height_reg;
    assign o_pixel_format   = fmt_reg[bfr_pkg::FMT_PIX_LSB +: 2];
    // X-Y mode puts (0,0) at top-left
    assign o_linear_mode    = (loc == bfr_pkg::LOC_LINEAR);
    assign o_xy_mode        = ~o_linear_mode;
    assign o_pat_addr_en    = ovr | o_linear_mode;
    assign o_pat_origin_valid = ovr | (loc[3:2] == 2'b11);
    assign o_pat_origin_row = o_pat_origin_valid ? row_raw : 3'h0;
    assign o_pat_origin_col = o_pat_origin_valid ? col_raw : 3'h0;

    // Format 10 has no compare layout; keep all 24 bits there
    assign fmt_mask =
        (o_pixel_format == bfr_pkg::PIX_8)  ? 24'h0000ff :
        (o_pixel_format == bfr_pkg::PIX_16) ? 24'h00ffff : 24'hffffff;
    assign o_color_compare    = cmp_reg & fmt_mask;
    assign o_foreground_color = fg_reg & fmt_mask;

    // ==========================================================
    // Pattern row rotation by the origin column
    // ==========================================================
    logic [PIX_W*PAT_N-1:0] rot_next;

    genvar gi;
    generate
        for (gi = 0; gi < PAT_N; gi++)
        begin : g_rot
            // Index worked out in int so the sum cannot wrap at 3 bits before the modulo
            assign rot_next[gi*PIX_W +: PIX_W] =
                i_pat_row[((gi + int'(o_pat_origin_col)) % PAT_N)*PIX_W
                          +: PIX_W];
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_pat_row_rot <= '0;
        else
            o_pat_row_rot <= rot_next;
    end

endmodule : bfr_regs

`default_nettype wire

// >>> sim/bfr_regs_monitor.sv
// Port checker for the format register bank.
// Assumes writes always carry all four byte lanes.
`timescale 1ns/1ps
`default_nettype none
module bfr_regs_monitor #(
    parameter int PIX_W = 8,
    parameter int PAT_N = 8
) (
    input wire logic                   i_clk,
    input wire logic                   i_rst_b,
    input wire logic [7:0]             i_avs_address,
    input wire logic                   i_avs_read,
    input wire logic                   i_avs_write,
    input wire logic [31:0]            i_avs_writedata,
    input wire logic [31:0]            o_avs_readdata,
    input wire logic                   o_avs_waitrequest,
    input wire logic [PIX_W*PAT_N-1:0] i_pat_row,
    input wire logic [PIX_W*PAT_N-1:0] o_pat_row_rot,
    input wire logic [11:0]            o_stretch_height,
    input wire logic [1:0]             o_pixel_format,
    input wire logic                   o_linear_mode,
    input wire logic                   o_xy_mode,
    input wire logic                   o_pat_addr_en,
    input wire logic                   o_pat_origin_valid,
    input wire logic [2:0]             o_pat_origin_row,
    input wire logic [2:0]             o_pat_origin_col,
    input wire logic [23:0]            o_color_compare,
    input wire logic [23:0]            o_foreground_color
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic wr_ok = i_avs_write && !o_avs_waitrequest;
    wire logic rd_ok = i_avs_read && !o_avs_waitrequest;
    // ==========================================================
    // Properties
    // ==========================================================
    property p_xy; o_xy_mode == !o_linear_mode; endproperty
    a_xy: assert property (p_xy) else $error("xy mode wrong");
    property p_lin; o_linear_mode |-> o_pat_addr_en; endproperty
    a_lin: assert property (p_lin) else $error("linear addr");
    property p_ovr; o_pat_addr_en |-> o_pat_origin_valid; endproperty
    a_ovr: assert property (p_ovr) else $error("overwrite");
    property p_org; !o_pat_origin_valid |-> o_pat_origin_row == 3'h0
        && o_pat_origin_col == 3'h0; endproperty
    a_org: assert property (p_org) else $error("origin shown");
    property p_hgt; wr_ok && i_avs_address == 8'h70 |=>
        o_stretch_height == $past(i_avs_writedata[11:0]); endproperty
    a_hgt: assert property (p_hgt) else $error("height");
    property p_pix; wr_ok && i_avs_address == 8'h78 |=>
        o_pixel_format == $past(i_avs_writedata[5:4]); endproperty
    a_pix: assert property (p_pix) else $error("pixel format");
    property p_c8; o_pixel_format == 2'h0 |-> o_color_compare[23:8] == 16'h0
        && o_foreground_color[23:8] == 16'h0; endproperty
    a_c8: assert property (p_c8) else $error("8-bit color");
    property p_rot; o_pat_origin_col == 3'h0 && $stable(o_pat_origin_col)
        |=> o_pat_row_rot == $past(i_pat_row); endproperty
    a_rot: assert property (p_rot) else $error("rotation");
    property p_rsv; rd_ok && i_avs_address == 8'h78 |->
        o_avs_readdata[31:15] == 17'h0 && o_avs_readdata[7:6] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    c_fmt: cover property (wr_ok && i_avs_address == 8'h78);
    c_xyo: cover property (o_pat_origin_valid && o_xy_mode);
    c_rd: cover property (rd_ok);
endmodule : bfr_regs_monitor
bind bfr_regs bfr_regs_monitor #(.PIX_W(PIX_W), .PAT_N(PAT_N)) u_mon (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_pat_row(i_pat_row),
    .o_pat_row_rot(o_pat_row_rot), .o_stretch_height(o_stretch_height),
    .o_pixel_format(o_pixel_format), .o_linear_mode(o_linear_mode),
    .o_xy_mode(o_xy_mode), .o_pat_addr_en(o_pat_addr_en),
    .o_pat_origin_valid(o_pat_origin_valid),
    .o_pat_origin_row(o_pat_origin_row), .o_pat_origin_col(o_pat_origin_col),
    .o_color_compare(o_color_compare),
    .o_foreground_color(o_foreground_color));
`default_nettype wire

// >>> sim/tb_bfr_regs.sv
// Self-checking random bench for the format register bank.
// Assumes package, design and monitor are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_bfr_regs;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wd = 32'h0;
    logic [63:0] pat = 64'h0;
    logic [31:0] rdd, rdv, v, f;
    logic [63:0] rot;
    logic [11:0] hgt;
    logic [1:0]  pix;
    logic        wq, lin, xy, pen, pval;
    logic [2:0]  prow, pcol;
    logic        ev;
    logic [2:0]  ec;
    logic [23:0] cmp, fg;
    logic [7:0]  tbl [5] = '{8'h50, 8'h70, 8'h78, 8'h80, 8'h44};
    int          errors = 0;
    int          cmp_count = 0;
    always #12.5 i_clk = ~i_clk;
    bfr_regs uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdd),
        .o_avs_waitrequest(wq), .i_pat_row(pat), .o_pat_row_rot(rot),
        .o_stretch_height(hgt), .o_pixel_format(pix), .o_linear_mode(lin),
        .o_xy_mode(xy), .o_pat_addr_en(pen), .o_pat_origin_valid(pval),
        .o_pat_origin_row(prow), .o_pat_origin_col(pcol),
        .o_color_compare(cmp), .o_foreground_color(fg));
    task automatic end_of_test();
        $display("Compared %0d, mismatched %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [63:0] s, e, input string nm);
        cmp_count++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Request held until the rising edge that samples waitrequest low
    task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {rd, wr, adr, wd} <= {r, !r, a, d};
        do @(posedge i_clk); while (wq !== 1'b0);
        rdv = rdd;
        {rd, wr} <= 2'b00;
    endtask : bus
    function automatic logic [31:0] rmask(input logic [7:0] a);
        case (a)
            8'h50, 8'h80: rmask = 32'h00ff_ffff;
            8'h70: rmask = 32'h0000_0fff;
            8'h78: rmask = {16'h0, bfr_pkg::FMT_WMASK};
            default: rmask = 32'h0;
        endcase
    endfunction : rmask
    initial
    begin
        #200us;
        errors++;
        end_of_test();
    end
    initial
    begin
        v = $urandom(32'hffe2);
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            v = (i < 5) ? 32'hffff_ffff : $urandom();
            bus(1'b0, tbl[i % 5], v);
            bus(1'b1, tbl[i % 5], 32'h0);
            chk(rdv, v & rmask(tbl[i % 5]), "readback");
        end
        $display("Test readback done");
        for (int i = 0; i < 64; i++)
        begin
            f = $urandom();
            f[5:0] = i[5:0];
            f[14] = i[4] ^ i[5];
            v = $urandom();
            pat <= {$urandom(), $urandom()};
            bus(1'b0, 8'h78, f);
            bus(1'b0, 8'h80, v);
            bus(1'b0, 8'h50, v);
            bus(1'b0, 8'h70, v);
            @(negedge i_clk);
            ev = f[14] | (f[3:2] == 2'h3);
            ec = ev ? f[10:8] : 3'h0;
            chk(pix, f[5:4], "format");
            chk({lin, xy}, {f[3:0] == 4'hf, f[3:0] != 4'hf}, "mode");
            chk(pen, f[14] | (f[3:0] == 4'hf), "addr_en");
            chk(pval, ev, "valid");
            chk({prow, pcol}, ev ? f[13:8] : 6'h0, "origin");
            chk(rot, {pat, pat} >> (8 * ec), "rotate");
            chk(hgt, v[11:0], "height");
            chk(cmp, v[23:0] & (f[5] ? 24'hffffff : f[4] ? 24'hffff
                : 24'hff), "compare");
            chk(fg, v[23:0] & (f[5] ? 24'hffffff : f[4] ? 24'hffff
                : 24'hff), "foreground");
        end
        $display("Test format done");
        end_of_test();
    end
endmodule : tb_bfr_regs
`default_nettype wire
